// ===== src/ccr_channel_config.sv
// Purpose: channel 4 configuration registers and channel 3 phase delay
// Assumes: register port already decoded from the control interface
// Notes: reserved codes are stored but flagged
`timescale 1ns/10ps
module ccr_channel_config #(
   parameter int SAMPLE_W = 1
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [7:0] regPage,
   input wire logic [7:0] regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   output logic regRdValid,
   input wire logic globalRangeGainctlConfig3,
   input wire logic modTick,
   input wire logic [SAMPLE_W-1:0] chan3SampleIn,
   output logic [SAMPLE_W-1:0] chan3SampleOut,
   output logic chan4MicOrLine,
   output logic [1:0] chan4SourceSelect,
   output logic chan4Analog,
   output logic chan4Pdm,
   output logic chan4CouplingSelect,
   output logic [1:0] chan4ImpedanceSelect,
   output logic chan4RangeEnhanceOn,
   output logic chan4GainCtlOn,
   output logic [5:0] chan4GainCode,
   output logic [7:0] chan4VolumeCode,
   output logic chan4Mute,
   output logic [3:0] chan4GainTrimCode,
   output logic chan4ReservedCode
);
   import ccr_pkg::*;

   ////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [7:0] phase;
      logic [7:0] setup;
      logic [7:0] gain;
      logic [7:0] volume;
      logic [7:0] trim;
      logic [7:0] rdData;
      logic rdValid;
      logic [7:0] wrPtr;
      logic [SAMPLE_W-1:0] sampleOut;
      logic [SAMPLE_W-1:0] lastIn;
      logic outPending;
      logic [1:0] src;
      logic micOrLine;
      logic analog;
      logic pdm;
      logic coupling;
      logic [1:0] imp;
      logic rangeOn;
      logic gainCtlOn;
      logic [5:0] gainCode;
      logic mute;
      logic reserved;
   } ccr_state_t;

   ccr_state_t cur;
   ccr_state_t next_cur;
   logic pageHit;
   logic [SAMPLE_W-1:0] memRdData;
   logic [7:0] rdAddr;

   assign pageHit = (regPage == CCR_PAGE);
   // zero delay bypasses memory; otherwise read the sample phase ticks old
   assign rdAddr = cur.wrPtr - cur.phase;

   ////////////////////////////////////////////////////////////////////
   ccr_delay_mem #(
      .WIDTH(SAMPLE_W),
      .DEPTH(PHASE_DEPTH),
      .AW(8)
   ) u_mem (
      .ref_clk(ref_clk),
      .wrEn(modTick),
      .wrAddr(cur.wrPtr),
      .wrData(chan3SampleIn),
      .rdEn(modTick),
      .rdAddr(rdAddr),
      .rdData(memRdData)
   );

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      next_cur = cur;
      next_cur.rdValid = 1'b0;
      if (regWrite && pageHit) begin
         unique case (regAddr)
            ADDR_PHASE: next_cur.phase = regWrData;
            ADDR_SETUP: next_cur.setup = regWrData & MASK_SETUP;
            ADDR_GAIN: next_cur.gain = regWrData & MASK_GAIN;
            ADDR_VOLUME: next_cur.volume = regWrData;
            ADDR_TRIM: next_cur.trim = regWrData & MASK_TRIM;
            default: ;
         endcase
      end
      if (regRead) begin
         next_cur.rdValid = 1'b1;
         next_cur.rdData = 8'h00;
         if (pageHit) begin
            unique case (regAddr)
               ADDR_PHASE: next_cur.rdData = cur.phase;
               ADDR_SETUP: next_cur.rdData = cur.setup;
               ADDR_GAIN: next_cur.rdData = cur.gain;
               ADDR_VOLUME: next_cur.rdData = cur.volume;
               ADDR_TRIM: next_cur.rdData = cur.trim;
               default: next_cur.rdData = 8'h00;
            endcase
         end
      end
      // decoded settings follow the stored registers one cycle later
      next_cur.micOrLine = cur.setup[BIT_TYPE];
      next_cur.src = cur.setup[SRC_HI:SRC_LO];
      next_cur.analog = (cur.setup[SRC_HI:SRC_LO] == 2'h0)
         || (cur.setup[SRC_HI:SRC_LO] == 2'h1);
      next_cur.pdm = (cur.setup[SRC_HI:SRC_LO] == 2'h2);
      // coupling forced off for non-analog sources; impedance passes through ungated
      next_cur.coupling = next_cur.analog && cur.setup[BIT_COUPLING];
      next_cur.imp = cur.setup[IMP_HI:IMP_LO];
      next_cur.rangeOn = cur.setup[BIT_RANGE_EN] && !globalRangeGainctlConfig3;
      next_cur.gainCtlOn = cur.setup[BIT_RANGE_EN] && globalRangeGainctlConfig3;
      // reserved gain codes clamp to the top step rather than misbehave
      next_cur.gainCode = (cur.gain[GAIN_HI:GAIN_LO] > GAIN_MAX) ? GAIN_MAX
         : cur.gain[GAIN_HI:GAIN_LO];
      next_cur.mute = (cur.volume == VOL_MUTE);
      next_cur.reserved = (cur.setup[SRC_HI:SRC_LO] == SRC_RESERVED)
         || (cur.setup[IMP_HI:IMP_LO] == IMP_RESERVED)
         || (cur.gain[GAIN_HI:GAIN_LO] > GAIN_MAX);
      next_cur.outPending = modTick;
      if (modTick) begin
         next_cur.wrPtr = cur.wrPtr + 8'h01;
         next_cur.lastIn = chan3SampleIn;
      end
      if (cur.outPending) begin
         // zero phase reads the same entry it writes, so memory would give a stale sample
         next_cur.sampleOut = (cur.phase == 8'h00) ? cur.lastIn : memRdData;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cur <= '0;
         cur.phase <= RST_PHASE;
         cur.setup <= RST_SETUP;
         cur.gain <= RST_GAIN;
         cur.volume <= RST_VOLUME;
         cur.trim <= RST_TRIM;
      end else begin
         cur <= next_cur;
      end
   end

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      regRdData = cur.rdData;
      regRdValid = cur.rdValid;
      chan3SampleOut = cur.sampleOut;
      chan4MicOrLine = cur.micOrLine;
      chan4SourceSelect = cur.src;
      chan4Analog = cur.analog;
      chan4Pdm = cur.pdm;
      chan4CouplingSelect = cur.coupling;
      chan4ImpedanceSelect = cur.imp;
      chan4RangeEnhanceOn = cur.rangeOn;
      chan4GainCtlOn = cur.gainCtlOn;
      chan4GainCode = cur.gainCode;
      chan4VolumeCode = cur.volume;
      chan4Mute = cur.mute;
      chan4GainTrimCode = cur.trim[TRIM_HI:TRIM_LO];
      chan4ReservedCode = cur.reserved;
   end
endmodule

// ===== src/ccr_pkg.sv
// Purpose: constants for the channel configuration register slice
// Assumes: byte-wide register port on page 0, one clock ref_clk at 25 MHz
// Notes: decoded setting outputs feed the channel datapath
package ccr_pkg;
   localparam logic [7:0] CCR_PAGE = 8'h00;
   localparam logic [7:0] ADDR_PHASE = 8'h4A;
   localparam logic [7:0] ADDR_SETUP = 8'h4B;
   localparam logic [7:0] ADDR_GAIN = 8'h4C;
   localparam logic [7:0] ADDR_VOLUME = 8'h4D;
   localparam logic [7:0] ADDR_TRIM = 8'h4E;
   localparam logic [7:0] RST_PHASE = 8'h00;
   localparam logic [7:0] RST_SETUP = 8'h00;
   localparam logic [7:0] RST_GAIN = 8'h00;
   localparam logic [7:0] RST_VOLUME = 8'hC9;
   localparam logic [7:0] RST_TRIM = 8'h80;
   localparam logic [7:0] MASK_SETUP = 8'hFD;
   localparam logic [7:0] MASK_GAIN = 8'hFC;
   localparam logic [7:0] MASK_TRIM = 8'hF0;
   localparam int BIT_TYPE = 7;
   localparam int SRC_HI = 6;
   localparam int SRC_LO = 5;
   localparam int BIT_COUPLING = 4;
   localparam int IMP_HI = 3;
   localparam int IMP_LO = 2;
   localparam int BIT_RANGE_EN = 0;
   localparam int GAIN_HI = 7;
   localparam int GAIN_LO = 2;
   localparam int TRIM_HI = 7;
   localparam int TRIM_LO = 4;
   localparam int GLOBAL_SEL_BIT = 3;
   localparam logic [1:0] SRC_RESERVED = 2'h3;
   localparam logic [1:0] IMP_RESERVED = 2'h3;
   localparam logic [5:0] GAIN_MAX = 6'h2A;
   localparam logic [7:0] VOL_MUTE = 8'h00;
   localparam int PHASE_DEPTH = 256;
endpackage

// ===== src/ccr_delay_mem.sv
// Purpose: sample store for the phase delay line
// Assumes: one write and one read per modulator tick
// Notes: read data registered
`timescale 1ns/10ps
module ccr_delay_mem #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 256,
   parameter int AW = 8
) (
   input wire logic ref_clk,
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [WIDTH-1:0] wrData,
   input wire logic rdEn,
   input wire logic [AW-1:0] rdAddr,
   output logic [WIDTH-1:0] rdData
);
   logic [WIDTH-1:0] mem [DEPTH];
   always_ff @(posedge ref_clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      if (rdEn) begin
         rdData <= mem[rdAddr];
      end
   end
endmodule

// ===== verif/ccr_cfg_asserts.sv
// Purpose: port-level checks for the channel config slice
// Assumes: ports of ccr_channel_config only
// Notes: bound from the foot of this file
`timescale 1ns/10ps
module ccr_cfg_asserts (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [7:0] regPage,
   input wire logic regRead,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid,
   input wire logic [1:0] chan4SourceSelect,
   input wire logic chan4Analog,
   input wire logic chan4Pdm,
   input wire logic chan4CouplingSelect,
   input wire logic chan4RangeEnhanceOn,
   input wire logic chan4GainCtlOn,
   input wire logic [5:0] chan4GainCode,
   input wire logic [7:0] chan4VolumeCode,
   input wire logic chan4Mute
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   chk_read_answer: assert property (regRead |=> regRdValid)
      else $error("read not answered");
   chk_page_refused: assert property (regRead && regPage != 8'h00 |=> regRdData == 8'h00)
      else $error("other page read not zero");
   chk_pdm_decode: assert property (chan4Pdm == (chan4SourceSelect == 2'h2))
      else $error("pdm decode wrong");
   // outputs still hold reset zeros at the first edge after release
   chk_analog_decode: assert property (!$past(sys_rst) |-> chan4Analog == !chan4SourceSelect[1])
      else $error("analog decode wrong");
   chk_dc_analog: assert property (chan4CouplingSelect |-> chan4Analog)
      else $error("dc coupling on non-analog source");
   chk_range_excl: assert property (!(chan4RangeEnhanceOn && chan4GainCtlOn))
      else $error("both range and gain control on");
   chk_gain_limit: assert property (chan4GainCode <= 6'h2A)
      else $error("gain beyond 42");
   chk_mute_zero: assert property ((chan4VolumeCode == 8'h00) [*2] |-> chan4Mute)
      else $error("volume zero not muted");
endmodule
////////////////////////////////////////////////////////////////////////
bind ccr_channel_config ccr_cfg_asserts u_chk (.ref_clk, .sys_rst, .regPage, .regRead,
   .regRdData, .regRdValid, .chan4SourceSelect, .chan4Analog, .chan4Pdm, .chan4CouplingSelect,
   .chan4RangeEnhanceOn, .chan4GainCtlOn, .chan4GainCode, .chan4VolumeCode, .chan4Mute);

// ===== verif/channel_config_registers_tb_top.sv
// Purpose: self-checking bench for the channel config slice
// Assumes: reads answer one cycle after the taking edge
// Notes: driver queues expected read bytes, monitor pops them
`timescale 1ns/10ps
module channel_config_registers_tb_top;
   import ccr_pkg::*;
   logic ref_clk = '0, sys_rst = '1, regWrite = '0, regRead = '0, modTick = '0;
   logic globalRangeGainctlConfig3 = '0, regRdValid, chan4RangeEnhanceOn, chan4GainCtlOn, chan4Mute;
   logic [7:0] regPage = '0, regAddr = '0, regWrData = '0, regRdData, v;
   logic [0:0] chan3SampleIn = '0, chan3SampleOut;
   logic chan4MicOrLine, chan4Analog, chan4Pdm, chan4CouplingSelect, chan4ReservedCode;
   logic [1:0] chan4SourceSelect, chan4ImpedanceSelect;
   logic [3:0] chan4GainTrimCode;
   logic [5:0] chan4GainCode;
   logic [7:0] chan4VolumeCode;
   logic [7:0] sh[5] = '{8'h00, 8'h00, 8'h00, 8'hC9, 8'h80};
   logic [7:0] q[$], hist[$];
   logic [7:0] rv[5] = '{8'h00, 8'h00, 8'h00, 8'hC9, 8'h80};
   logic [7:0] mk[5] = '{8'hFF, 8'hFD, 8'hFC, 8'hFF, 8'hF0};
   int failures = 0, n_checks = 0, seed = 32'h9077C9ED;
   ccr_channel_config uut (.ref_clk, .sys_rst, .regPage, .regAddr, .regWrite, .regRead,
      .regWrData, .regRdData, .regRdValid, .globalRangeGainctlConfig3, .modTick, .chan3SampleIn,
      .chan3SampleOut, .chan4MicOrLine, .chan4SourceSelect, .chan4Analog, .chan4Pdm,
      .chan4CouplingSelect, .chan4ImpedanceSelect, .chan4RangeEnhanceOn, .chan4GainCtlOn,
      .chan4GainCode, .chan4VolumeCode, .chan4Mute, .chan4GainTrimCode, .chan4ReservedCode);
   initial forever #20 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////////////
   task automatic cyc(int n = 1);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // strobes stay up between back-to-back requests
   task automatic wr(logic [7:0] a, logic [7:0] d);
      regRead = 1'h0;
      regAddr = a;
      regWrData = d;
      regWrite = 1'h1;
      cyc();
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      regWrite = 1'h0;
      regAddr = a;
      regRead = 1'h1;
      q.push_back(e);
      cyc();
   endtask
   task automatic idle();
      regWrite = 1'h0;
      regRead = 1'h0;
      cyc(2);
   endtask
   task automatic cmp(logic [7:0] g, logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cmp_cfg(logic [7:0] g, logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // decoded settings against the shadow copy of what was written
   task automatic chk_dec();
      logic [1:0] s;
      logic [1:0] m;
      logic [5:0] g;
      s = sh[1][6:5];
      m = sh[1][3:2];
      g = sh[2][7:2];
      cmp_cfg(8'(chan4MicOrLine), 8'(sh[1][7]));
      cmp_cfg(8'({chan4Pdm, chan4Analog, chan4SourceSelect}), 8'({s == 2'h2, s < 2'h2, s}));
      cmp_cfg(8'(chan4CouplingSelect), 8'(sh[1][4] && s < 2'h2));
      cmp_cfg(8'(chan4ImpedanceSelect), 8'(m));
      cmp_cfg(8'({chan4RangeEnhanceOn, chan4GainCtlOn}), 8'({sh[1][0], 1'h0}));
      cmp_cfg(8'(chan4GainCode), 8'((g > GAIN_MAX) ? GAIN_MAX : g));
      cmp_cfg(8'(chan4ReservedCode), 8'(s == 2'h3 || m == 2'h3 || g > GAIN_MAX));
      cmp_cfg(8'(chan4Mute), 8'(sh[3] == 8'h00));
      cmp_cfg(chan4VolumeCode, sh[3]);
      cmp_cfg(8'(chan4GainTrimCode), 8'(sh[4][7:4]));
   endtask
   // ticks four cycles apart; only samples sent in this run are compared
   task automatic delay_run(logic [7:0] p, int n);
      wr(ADDR_PHASE, p);
      idle();
      hist.delete();
      repeat (n) begin
         chan3SampleIn = 1'($random(seed));
         modTick = 1'h1;
         hist.push_front(8'(chan3SampleIn));
         cyc();
         modTick = 1'h0;
         cyc(2);
         if (hist.size() > p) cmp_cfg(8'(chan3SampleOut), hist[p]);
         cyc();
      end
   endtask
   task automatic end_of_test();
      if (failures == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk)
      if (regRdValid === 1'h1) cmp(regRdData, q.size() ? q.pop_front() : 8'hXX);
   initial begin
      // tests take about 1.4k cycles
      #200000;
      failures++;
      end_of_test();
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      #1 sys_rst = 1'h0;
      for (int i = 0; i < 5; i++) rd(8'h4A + i, rv[i]);
      chk_dec();
      repeat (20) for (int i = 0; i < 5; i++) begin
         v = $random(seed);
         wr(8'h4A + i, v);
         rd(8'h4A + i, v & mk[i]);
         sh[i] = v & mk[i];
         chk_dec();
      end
      wr(8'h4F, 8'hFF);
      rd(8'h4F, 8'h00);
      wr(8'h4D, 8'h05);
      regPage = 8'h01;
      wr(8'h4D, 8'h00);
      rd(8'h4D, 8'h00);
      regPage = 8'h00;
      rd(8'h4D, 8'h05);
      wr(8'h4D, 8'h00);
      wr(8'h4B, 8'h01);
      idle();
      cmp(chan4Mute, 8'h01);
      cmp({chan4RangeEnhanceOn, chan4GainCtlOn}, 8'h02);
      globalRangeGainctlConfig3 = 1'h1;
      cyc(2);
      cmp({chan4RangeEnhanceOn, chan4GainCtlOn}, 8'h01);
      wr(8'h4B, 8'h00);
      idle();
      cmp({chan4RangeEnhanceOn, chan4GainCtlOn}, 8'h00);
      delay_run(8'h05, 16);
      delay_run(8'h00, 8);
      delay_run(8'hFF, 260);
      end_of_test();
   end
endmodule
